// >>> include/hspc_pkg.sv
// constants and types for the halt and standby power control block
`default_nettype none
package hspc_pkg;
    localparam int         ADDR_W      = 12;
    localparam logic [11:0] RESET_VECTOR = 12'h000;
    localparam int         SYNC_STAGES = 2;
    localparam int         T0_DIV      = 15;
    localparam logic [1:0] IRQ_NONE    = 2'h0;
    localparam logic [1:0] IRQ_ENABLED = 2'h1;

    typedef enum logic [3:0] {
        HSPC_RUN     = 4'h1,
        HSPC_HALT    = 4'h2,
        HSPC_WAKE    = 4'h4,
        HSPC_STANDBY = 4'h8
    } hspc_state_t;
endpackage : hspc_pkg
`default_nettype wire

// >>> include/hspc_sync_if.sv
// synchronised pin levels passed from the input stage to the controller
`timescale 1ns/1ps
`default_nettype none
interface hspc_sync_if;
    logic reset_n;
    logic sleep_request_n;
    logic irq_n;
    logic event_count_in;
    modport src (output reset_n, output sleep_request_n, output irq_n,
                 output event_count_in);
    modport dst (input reset_n, input sleep_request_n, input irq_n,
                 input event_count_in);
endinterface : hspc_sync_if
`default_nettype wire

// >>> rtl/hspc_sync.sv
// two-flop synchronisers for the asynchronous control pins
`timescale 1ns/1ps
`default_nettype none
module hspc_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] pins_i,
    hspc_sync_if.src              sync
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] stable_reg;
    logic [WIDTH-1:0] stable_next;

    always_comb begin
        meta_next   = pins_i;
        stable_next = meta_reg;
    end

    // idle high for active-low pins, low for counter input
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg   <= WIDTH'(4'h7);
            stable_reg <= WIDTH'(4'h7);
        end else begin
            meta_reg   <= meta_next;
            stable_reg <= stable_next;
        end
    end

    assign sync.reset_n         = stable_reg[0];
    assign sync.sleep_request_n = stable_reg[1];
    assign sync.irq_n           = stable_reg[2];
    assign sync.event_count_in  = stable_reg[3];
endmodule : hspc_sync
`default_nettype wire

// >>> rtl/hspc_ctrl.sv
// halt and standby power controller of an 8-bit microcontroller
// What this block does
// - a halt instruction stops execution and enters halt mode.
// - in halt the base clock and the test0 divider keep running, the core is stopped.
// - register contents are kept unchanged throughout halt.
// - in halt the data bus keeps driving if output, floats if input.
// - an enabled test0 clock output keeps running through halt.
// - in halt the first event pulse still counts, the timer stays still.
// - after halt the event counter resumes from its kept value.
// - reset low ends halt, reinitialises and restarts at address 0.
// - interrupt low with irqs on ends halt, runs two more, then irq.
// - interrupt low with irqs off ends halt, resumes after halt.
// - standby stops all operation including the oscillator clock.
// - standby keeps only the on-chip ram contents.
// - reset release after standby reinitialises and starts at 0.
`timescale 1ns/1ps
`default_nettype none
module hspc_ctrl #(
    parameter int ADDR_W = hspc_pkg::ADDR_W,
    parameter int CNT_W  = 8
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              reset_n_i,
    input  wire logic              sleep_request_n_i,
    input  wire logic              irq_n_i,
    input  wire logic              event_count_in_i,
    input  wire logic              halt_exec_i,
    input  wire logic              irq_enable_i,
    input  wire logic              counter_mode_i,
    input  wire logic              timer_run_i,
    input  wire logic              test0_clk_en_i,
    input  wire logic              bus_out_mode_i,
    input  wire logic              instr_done_i,
    input  wire logic [ADDR_W-1:0] halt_pc_i,
    output logic                   core_run_o,
    output logic                   core_reset_o,
    output logic                   osc_run_o,
    output logic                   ram_hold_o,
    output logic                   halted_o,
    output logic                   standby_o,
    output logic                   pin_park_o,
    output logic                   bus_drive_o,
    output logic                   latch_strobe_o,
    output logic                   prog_fetch_strobe_o,
    output logic                   read_strobe_o,
    output logic                   test0_clock_out_o,
    output logic                   irq_take_o,
    output logic                   resume_load_o,
    output logic [ADDR_W-1:0]      resume_pc_o,
    output logic                   timer_tick_o,
    output logic [CNT_W-1:0]       event_count_o
);
    hspc_sync_if s ();

    hspc_sync #(
        .WIDTH (4)
    ) u_sync (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .pins_i ({event_count_in_i, irq_n_i, sleep_request_n_i,
                  reset_n_i}),
        .sync   (s)
    );

    hspc_pkg::hspc_state_t state_reg;
    hspc_pkg::hspc_state_t state_next;
    logic [1:0]            wake_left_reg;
    logic [1:0]            wake_left_next;
    logic                  irq_path_reg;
    logic                  irq_path_next;
    logic [ADDR_W-1:0]     pc_keep_reg;
    logic [ADDR_W-1:0]     pc_keep_next;
    logic [ADDR_W-1:0]     resume_pc_reg;
    logic [ADDR_W-1:0]     resume_pc_next;
    logic                  resume_reg;
    logic                  resume_next;
    logic                  irq_take_reg;
    logic                  irq_take_next;
    logic                  core_reset_reg;
    logic                  core_reset_next;

    // control state machine
    always_comb begin
        state_next      = state_reg;
        wake_left_next  = wake_left_reg;
        irq_path_next   = irq_path_reg;
        pc_keep_next    = pc_keep_reg;
        resume_pc_next  = resume_pc_reg;
        resume_next     = 1'b0;
        irq_take_next   = 1'b0;
        core_reset_next = !s.reset_n;
        unique case (state_reg)
            hspc_pkg::HSPC_RUN: begin
                if (!s.reset_n && !s.sleep_request_n) begin
                    state_next = hspc_pkg::HSPC_STANDBY;
                end else if (halt_exec_i && s.reset_n) begin
                    state_next   = hspc_pkg::HSPC_HALT;
                    pc_keep_next = halt_pc_i;
                end
            end
            hspc_pkg::HSPC_HALT: begin
                if (!s.reset_n) begin
                    state_next     = hspc_pkg::HSPC_RUN;
                    resume_pc_next = ADDR_W'(hspc_pkg::RESET_VECTOR);
                end else if (!s.irq_n) begin
                    state_next     = hspc_pkg::HSPC_RUN;
                    resume_next    = 1'b1;
                    resume_pc_next = ADDR_W'(pc_keep_reg + 1'b1);
                    irq_path_next  = irq_enable_i;
                    wake_left_next = 2'h2;
                    if (irq_enable_i) begin
                        state_next = hspc_pkg::HSPC_WAKE;
                    end
                end
            end
            hspc_pkg::HSPC_WAKE: begin
                if (!s.reset_n) begin
                    state_next     = hspc_pkg::HSPC_RUN;
                    resume_pc_next = ADDR_W'(hspc_pkg::RESET_VECTOR);
                end else if (instr_done_i) begin
                    wake_left_next = wake_left_reg - 2'h1;
                    if (wake_left_reg == 2'h1) begin
                        irq_take_next = irq_path_reg;
                        state_next    = hspc_pkg::HSPC_RUN;
                    end
                end
            end
            hspc_pkg::HSPC_STANDBY: begin
                core_reset_next = 1'b1;
                if (s.sleep_request_n && s.reset_n) begin
                    state_next     = hspc_pkg::HSPC_RUN;
                    resume_pc_next = ADDR_W'(hspc_pkg::RESET_VECTOR);
                    core_reset_next = 1'b0;
                end
            end
            default: begin
                state_next = hspc_pkg::HSPC_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg      <= hspc_pkg::HSPC_RUN;
            wake_left_reg  <= 2'h0;
            irq_path_reg   <= 1'b0;
            pc_keep_reg    <= '0;
            resume_pc_reg  <= '0;
            resume_reg     <= 1'b0;
            irq_take_reg   <= 1'b0;
            core_reset_reg <= 1'b1;
        end else begin
            state_reg      <= state_next;
            wake_left_reg  <= wake_left_next;
            irq_path_reg   <= irq_path_next;
            pc_keep_reg    <= pc_keep_next;
            resume_pc_reg  <= resume_pc_next;
            resume_reg     <= resume_next;
            irq_take_reg   <= irq_take_next;
            core_reset_reg <= core_reset_next;
        end
    end

    // pin parking, test0 clock, timer and event counter
    logic             halt_now;
    logic             sleep_request_n_now;
    logic [3:0]       div_reg;
    logic [3:0]       div_next;
    logic             t0_reg;
    logic             t0_next;
    logic             ev_last_reg;
    logic             ev_last_next;
    logic             ev_halt_seen_reg;
    logic             ev_halt_seen_next;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic             tick_reg;
    logic             tick_next;
    logic             bus_reg;
    logic             bus_next;
    logic             ale_reg;
    logic             ale_next;
    logic             fetch_reg;
    logic             fetch_next;
    logic             rd_reg;
    logic             rd_next;
    logic             ev_rise;

    always_comb begin
        halt_now = (state_next == hspc_pkg::HSPC_HALT);
        sleep_request_n_now = (state_next == hspc_pkg::HSPC_STANDBY);
        ev_rise  = s.event_count_in && !ev_last_reg;
        div_next = div_reg;
        t0_next  = t0_reg;
        tick_next = 1'b0;
        count_next = count_reg;
        ev_last_next = s.event_count_in;
        ev_halt_seen_next = halt_now ? ev_halt_seen_reg : 1'b0;
        if (!sleep_request_n_now) begin
            if (div_reg == 4'(hspc_pkg::T0_DIV - 1)) begin
                div_next  = 4'h0;
                t0_next   = !t0_reg;
                tick_next = timer_run_i && !counter_mode_i && !halt_now;
            end else begin
                div_next = div_reg + 4'h1;
            end
        end
        if (counter_mode_i && ev_rise && !sleep_request_n_now) begin
            if (!halt_now) begin
                count_next = count_reg + 1'b1;
            end else if (!ev_halt_seen_reg) begin
                count_next        = count_reg + 1'b1;
                ev_halt_seen_next = 1'b1;
            end
        end
        bus_next   = bus_out_mode_i && !sleep_request_n_now;
        ale_next   = !(halt_now || sleep_request_n_now);
        fetch_next = 1'b1;
        rd_next    = 1'b1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_reg          <= 4'h0;
            t0_reg           <= 1'b0;
            ev_last_reg      <= 1'b0;
            ev_halt_seen_reg <= 1'b0;
            count_reg        <= '0;
            tick_reg         <= 1'b0;
            bus_reg          <= 1'b0;
            ale_reg          <= 1'b0;
            fetch_reg        <= 1'b1;
            rd_reg           <= 1'b1;
        end else begin
            div_reg          <= div_next;
            t0_reg           <= t0_next;
            ev_last_reg      <= ev_last_next;
            ev_halt_seen_reg <= ev_halt_seen_next;
            count_reg        <= count_next;
            tick_reg         <= tick_next;
            bus_reg          <= bus_next;
            ale_reg          <= ale_next;
            fetch_reg        <= fetch_next;
            rd_reg           <= rd_next;
        end
    end

    // status outputs registered from the next-state decode
    logic run_reg;
    logic run_next;
    logic osc_reg;
    logic osc_next;
    logic t0o_reg;
    logic t0o_next;

    always_comb begin
        run_next = (state_next == hspc_pkg::HSPC_RUN ||
                    state_next == hspc_pkg::HSPC_WAKE) && s.reset_n;
        osc_next = (state_next != hspc_pkg::HSPC_STANDBY);
        t0o_next = test0_clk_en_i && t0_next && osc_next;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_reg <= 1'b0;
            osc_reg <= 1'b1;
            t0o_reg <= 1'b0;
        end else begin
            run_reg <= run_next;
            osc_reg <= osc_next;
            t0o_reg <= t0o_next;
        end
    end

    assign core_run_o          = run_reg;
    assign core_reset_o        = core_reset_reg;
    assign osc_run_o           = osc_reg;
    assign ram_hold_o          = state_reg[3];
    assign halted_o            = state_reg[1];
    assign standby_o           = state_reg[3];
    assign pin_park_o          = !ale_reg;
    assign bus_drive_o         = bus_reg;
    assign latch_strobe_o      = ale_reg;
    assign prog_fetch_strobe_o = fetch_reg;
    assign read_strobe_o       = rd_reg;
    assign test0_clock_out_o   = t0o_reg;
    assign irq_take_o          = irq_take_reg;
    assign resume_load_o       = resume_reg;
    assign resume_pc_o         = resume_pc_reg;
    assign timer_tick_o        = tick_reg;
    assign event_count_o       = count_reg;
endmodule : hspc_ctrl
`default_nettype wire

// >>> tb/hspc_ctrl_monitor.sv
// concurrent checks on the halt and standby controller ports
`timescale 1ns/1ps
`default_nettype none
module hspc_ctrl_monitor #(
    parameter int ADDR_W = hspc_pkg::ADDR_W
) (
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              reset_n_i,
    input wire logic              irq_n_i,
    input wire logic              halt_exec_i,
    input wire logic [ADDR_W-1:0] halt_pc_i,
    input wire logic              core_run_o,
    input wire logic              core_reset_o,
    input wire logic              osc_run_o,
    input wire logic              ram_hold_o,
    input wire logic              halted_o,
    input wire logic              standby_o,
    input wire logic              latch_strobe_o,
    input wire logic              prog_fetch_strobe_o,
    input wire logic              read_strobe_o,
    input wire logic              resume_load_o,
    input wire logic [ADDR_W-1:0] resume_pc_o,
    input wire logic              timer_tick_o
);
    logic [ADDR_W-1:0] pc_reg;
    logic [ADDR_W-1:0] pc_next;
    // address of the last accepted halt
    always_comb pc_next = (halt_exec_i && core_run_o) ? halt_pc_i : pc_reg;
    always_ff @(posedge clk_i) pc_reg <= pc_next;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_halt_entry: assert property (
        halt_exec_i && core_run_o |=> halted_o && !core_run_o)
        else $error("halt not entered");
    a_halt_stop: assert property (
        halted_o |-> !core_run_o && osc_run_o)
        else $error("core runs in halt");
    a_pin_park: assert property (
        halted_o |-> !latch_strobe_o && prog_fetch_strobe_o && read_strobe_o)
        else $error("strobes not parked");
    a_timer_still: assert property (
        halted_o && $past(halted_o) |-> !timer_tick_o)
        else $error("timer ticks in halt");
    a_resume_addr: assert property (
        resume_load_o |-> resume_pc_o == ADDR_W'(pc_reg + 1'b1))
        else $error("wrong resume address");
    a_irq_wake: assert property (
        halted_o && reset_n_i && $fell(irq_n_i) |-> ##[1:6] resume_load_o)
        else $error("irq did not end halt");
    a_reset_wake: assert property (
        halted_o && !reset_n_i |-> ##[1:5] core_reset_o && !halted_o)
        else $error("reset did not end halt");
    a_standby_off: assert property (
        standby_o |-> !osc_run_o && ram_hold_o && !core_run_o)
        else $error("standby not stopped");
endmodule : hspc_ctrl_monitor
bind hspc_ctrl hspc_ctrl_monitor #(.ADDR_W(ADDR_W)) u_hspc_ctrl_monitor (
    .clk_i(clk_i), .rst_i(rst_i), .reset_n_i(reset_n_i),
    .irq_n_i(irq_n_i), .halt_exec_i(halt_exec_i), .halt_pc_i(halt_pc_i),
    .core_run_o(core_run_o), .core_reset_o(core_reset_o),
    .osc_run_o(osc_run_o), .ram_hold_o(ram_hold_o), .halted_o(halted_o),
    .standby_o(standby_o), .latch_strobe_o(latch_strobe_o),
    .prog_fetch_strobe_o(prog_fetch_strobe_o),
    .read_strobe_o(read_strobe_o), .resume_load_o(resume_load_o),
    .resume_pc_o(resume_pc_o), .timer_tick_o(timer_tick_o)
);
`default_nettype wire

// >>> tb/hspc_pins.sv
// model of the outside reset, standby and interrupt circuitry
`timescale 1ns/1ps
`default_nettype none
module hspc_pins (
    input  wire logic clk_i,
    output var logic  reset_n_o,
    output var logic  sleep_request_n_o,
    output var logic  irq_n_o
);
    initial begin
        reset_n_o = 1'b1;
        sleep_request_n_o = 1'b1;
        irq_n_o = 1'b1;
    end
    // one edge, then return
    task drive(input logic r, input logic s, input logic q);
        @(posedge clk_i);
        reset_n_o <= r;
        sleep_request_n_o <= s;
        irq_n_o <= q;
    endtask : drive
    task sleep_enter;
        drive(1'b0, 1'b1, 1'b1);
        repeat (4) @(posedge clk_i);
        drive(1'b0, 1'b0, 1'b1);
    endtask : sleep_enter
    task sleep_exit;
        drive(1'b0, 1'b1, 1'b1);
        repeat (4) @(posedge clk_i);
        drive(1'b1, 1'b1, 1'b1);
    endtask : sleep_exit
endmodule : hspc_pins
`default_nettype wire

// >>> tb/hspc_ctrl_test.sv
// scenario testbench for the halt and standby controller
`timescale 1ns/1ps
`default_nettype none
module hspc_ctrl_test;
    logic clk_i = 1'b0, rst_i = 1'b1, halt_exec_i = 1'b0, irq_en = 1'b0;
    logic cnt_mode = 1'b0, tmr_run = 1'b0, t0_en = 1'b0, bus_out = 1'b1;
    logic done_i = 1'b0, ev_i = 1'b0;
    logic [11:0] halt_pc_i = 12'h000;
    wire logic reset_n, sleep_n, irq_n;
    logic core_run_o, core_reset_o, osc_run_o, ram_hold_o, halted_o;
    logic standby_o, pin_park_o, bus_drive_o, latch_strobe_o;
    logic prog_fetch_strobe_o, read_strobe_o, t0_o, irq_take_o;
    logic resume_load_o, timer_tick_o;
    logic [11:0] resume_pc_o;
    logic [7:0] count_o;
    int fail_count = 0;
    int checked = 0;
    always #5 clk_i = ~clk_i;
    hspc_pins u_hspc_pins (.clk_i(clk_i), .reset_n_o(reset_n),
        .sleep_request_n_o(sleep_n), .irq_n_o(irq_n));
    hspc_ctrl u_hspc_ctrl (.clk_i(clk_i), .rst_i(rst_i),
        .reset_n_i(reset_n), .sleep_request_n_i(sleep_n), .irq_n_i(irq_n),
        .event_count_in_i(ev_i), .halt_exec_i(halt_exec_i),
        .irq_enable_i(irq_en), .counter_mode_i(cnt_mode),
        .timer_run_i(tmr_run), .test0_clk_en_i(t0_en),
        .bus_out_mode_i(bus_out), .instr_done_i(done_i),
        .halt_pc_i(halt_pc_i), .core_run_o(core_run_o),
        .core_reset_o(core_reset_o), .osc_run_o(osc_run_o),
        .ram_hold_o(ram_hold_o), .halted_o(halted_o),
        .standby_o(standby_o), .pin_park_o(pin_park_o),
        .bus_drive_o(bus_drive_o), .latch_strobe_o(latch_strobe_o),
        .prog_fetch_strobe_o(prog_fetch_strobe_o),
        .read_strobe_o(read_strobe_o), .test0_clock_out_o(t0_o),
        .irq_take_o(irq_take_o), .resume_load_o(resume_load_o),
        .resume_pc_o(resume_pc_o), .timer_tick_o(timer_tick_o),
        .event_count_o(count_o));
    task stop_test;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test
    task chk(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("Error %0t: %s", $time, m);
        end
    endtask : chk
    // bounded wait: 0 resume, 1 core reset, 2 core run, 3 standby
    task wait_on(input int sel);
        int i;
        logic s;
        for (i = 0; i < 40; i++) begin
            @(posedge clk_i);
            #1;
            s = sel == 0 ? resume_load_o : sel == 1 ? core_reset_o :
                sel == 2 ? core_run_o : standby_o;
            if (s === 1'b1) break;
        end
        if (i == 40) begin
            fail_count++;
            $display("Error %0t: wait %0d timed out", $time, sel);
            stop_test();
        end
    endtask : wait_on
    task halt(input logic [11:0] pc);
        @(posedge clk_i);
        halt_exec_i <= 1'b1;
        halt_pc_i <= pc;
        @(posedge clk_i);
        halt_exec_i <= 1'b0;
        #1;
        chk(halted_o === 1'b1 && core_run_o === 1'b0, "no halt");
    endtask : halt
    task irq_wake;
        u_hspc_pins.drive(1'b1, 1'b1, 1'b0);
        wait_on(0);
        u_hspc_pins.drive(1'b1, 1'b1, 1'b1);
    endtask : irq_wake
    task done_pulse(output logic seen);
        seen = 1'b0;
        @(posedge clk_i);
        done_i <= 1'b1;
        @(posedge clk_i);
        done_i <= 1'b0;
        repeat (3) begin
            #1;
            if (irq_take_o === 1'b1) seen = 1'b1;
            @(posedge clk_i);
        end
    endtask : done_pulse
    task ev_pulse;
        @(posedge clk_i);
        ev_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        ev_i <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask : ev_pulse
    task t_irq_off;
        logic a, b;
        halt(12'h0A5);
        chk(latch_strobe_o === 1'b0 && prog_fetch_strobe_o === 1'b1 &&
            read_strobe_o === 1'b1, "strobes");
        chk(bus_drive_o === 1'b1, "bus not driven");
        chk(pin_park_o === 1'b1, "pins not parked");
        irq_wake();
        chk(resume_pc_o === 12'h0A6, "resume address");
        chk(pin_park_o === 1'b0, "pins still parked");
        done_pulse(a);
        done_pulse(b);
        chk(a === 1'b0 && b === 1'b0, "irq taken while off");
        $display("test irq_off ended");
    endtask : t_irq_off
    task t_irq_on;
        logic a, b;
        irq_en <= 1'b1;
        bus_out <= 1'b0;
        repeat (3) @(posedge clk_i);
        halt(12'h7FF);
        chk(bus_drive_o === 1'b0, "bus driven in input mode");
        irq_wake();
        chk(resume_pc_o === 12'h800, "resume address");
        done_pulse(a);
        done_pulse(b);
        chk(a === 1'b0 && b === 1'b1, "irq after two");
        irq_en <= 1'b0;
        $display("test irq_on ended");
    endtask : t_irq_on
    task t_count;
        logic [7:0] c;
        logic p;
        int n, k;
        n = 0;
        k = 0;
        cnt_mode <= 1'b1;
        tmr_run <= 1'b1;
        t0_en <= 1'b1;
        ev_pulse();
        c = count_o;
        cnt_mode <= 1'b0;
        repeat (40) begin
            @(posedge clk_i);
            #1;
            if (timer_tick_o === 1'b1) k++;
        end
        chk(k > 0, "timer idle in run");
        k = 0;
        halt(12'h300);
        p = t0_o;
        repeat (40) begin
            @(posedge clk_i);
            #1;
            if (t0_o !== p) n++;
            p = t0_o;
            if (timer_tick_o === 1'b1) k++;
        end
        chk(n >= 2 && k == 0, "clock out or timer in halt");
        @(posedge clk_i);
        cnt_mode <= 1'b1;
        ev_pulse();
        ev_pulse();
        chk(count_o === c + 8'h01, "first pulse only");
        irq_wake();
        ev_pulse();
        chk(count_o === c + 8'h02, "count resumes");
        $display("test count ended");
    endtask : t_count
    task t_reset;
        halt(12'h123);
        u_hspc_pins.drive(1'b0, 1'b1, 1'b1);
        wait_on(1);
        chk(halted_o === 1'b0, "still halted");
        u_hspc_pins.drive(1'b1, 1'b1, 1'b1);
        wait_on(2);
        chk(resume_pc_o === hspc_pkg::RESET_VECTOR, "not at 0");
        $display("test reset ended");
    endtask : t_reset
    task t_standby;
        halt(12'h055);
        irq_wake();
        u_hspc_pins.sleep_enter();
        wait_on(3);
        chk(osc_run_o === 1'b0 && ram_hold_o === 1'b1 &&
            core_run_o === 1'b0, "standby state");
        u_hspc_pins.sleep_exit();
        wait_on(2);
        chk(standby_o === 1'b0 && core_reset_o === 1'b0 &&
            resume_pc_o === hspc_pkg::RESET_VECTOR, "restart");
        $display("test standby ended");
    endtask : t_standby
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_on(2);
        t_irq_off();
        t_irq_on();
        t_count();
        t_reset();
        t_standby();
        stop_test();
    end
endmodule : hspc_ctrl_test
`default_nettype wire
